//--- rtl/ssm_consts.svh
// constants of the safety i/o status monitor: reset values and timing counts
// assumes a 200 MHz reference clock; included by bare name from rtl/
//
// Overview of operation
// - seven general inputs, each configured to request one chosen safety function
// - four general outputs, each configured to carry one acknowledge signal
// - a one-to-zero edge on an activation input starts the assigned function
// - input low means function active, input high means function not active
// - a dedicated reset input clears the latched error and resumes operation
// - torque-off acknowledge is one while the power stage is off, else zero
// - ready is one only when operational; zero at start-up and on errors
// - ready drops at once when the torque-off acknowledge is found faulty
// - standstill acknowledge is one only while monitored and within standstill limits
// - direction acknowledge is one only while monitored and moving the permitted way
// - range acknowledge is one only while monitored and within speed or position limits
// - standstill, direction and range acknowledges serve their fixed function groups
// - output zero is released high impedance, output one is driven
// - switched-on outputs are periodically switched off for one test pulse
// - switched-off outputs are periodically switched on for one test pulse
// - a periodic test finds shorts between outputs and treats them as faults
// - the on-test scan repeats with a period of about 200 ms
// - any detected error asserts the amplifier pulse-disable
// - the brake command is forwarded to the amplifier
// - while stop-one is active no other function is processed or started
// - either input low starts the delay; both low switch torque off at once
`ifndef SSM_CONSTS_SVH
`define SSM_CONSTS_SVH

`define SSM_CLK_PERIOD_NS 5
`define SSM_CLK_PER_MS 200000
`define SSM_SCAN_PERIOD_MS 200
`define SSM_SCAN_CYCLES (`SSM_SCAN_PERIOD_MS * `SSM_CLK_PER_MS)
`define SSM_TEST_PULSE_NS 500
`define SSM_TEST_PULSE_CYCLES ((`SSM_TEST_PULSE_NS + `SSM_CLK_PERIOD_NS - 1) / `SSM_CLK_PERIOD_NS)
`define SSM_SETTLE_CYCLES 2'h3
`define SSM_PIN_IDLE 1'b1
`define SSM_FB_RST 1'b0
`define SSM_OUT_RST 1'b0

`endif

//--- rtl/ssm_pkg.sv
// types of the safety i/o status monitor
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package ssm_pkg;

  // function that a general input requests
  typedef enum logic [2:0] {
    SSM_FN_STOP_TWO = 3'h0,
    SSM_FN_OPERATING_STOP = 3'h1,
    SSM_FN_LIMITED_SPEED = 3'h2,
    SSM_FN_SPEED_RANGE = 3'h3,
    SSM_FN_POS_DIR = 3'h4,
    SSM_FN_NEG_DIR = 3'h5,
    SSM_FN_LIMITED_INC = 3'h6,
    SSM_FN_NONE = 3'h7
  } ssm_func_e;

  localparam int SSM_NUM_FUNC = 7;
  typedef logic [SSM_NUM_FUNC-1:0] ssm_func_vec_t;

  // acknowledge that a general output carries
  typedef enum logic [1:0] {
    SSM_ACK_STANDSTILL = 2'h0,
    SSM_ACK_DIRECTION = 2'h1,
    SSM_ACK_RANGE = 2'h2,
    SSM_ACK_NONE = 2'h3
  } ssm_ack_sel_e;

  // output test scheduler states
  typedef enum logic [2:0] {
    SSM_SC_WAIT = 3'b001,
    SSM_SC_PULSE = 3'b010,
    SSM_SC_GAP = 3'b100
  } ssm_scan_e;

  // status from the motion monitoring core, same clock
  typedef struct packed {
    logic startup_done;
    logic internal_error;
    logic limit_violation;
    logic standstill_ok;
    logic direction_ok;
    logic range_ok;
    logic brake_request;
  } ssm_mon_s;

endpackage
`default_nettype wire

//--- rtl/ssm_sync.sv
// two-stage synchroniser for pin-level inputs
// assumes inputs are slow levels; no bus coherency across bits
`include "ssm_consts.svh"
`default_nettype none
module ssm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // asynchronous level in, synchronised level out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

//--- rtl/ssm_out_chan.sv
// one safe output channel: drive stage, test inversion and read-back check
// assumes i_fb is already synchronised and i_check is a one-cycle strobe
`include "ssm_consts.svh"
`default_nettype none
module ssm_out_chan (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_state,
  input wire logic i_test,
  input wire logic i_check,
  input wire logic i_fb,
  // pin and fault
  output logic o_drive,
  output logic o_oe_n,
  output logic o_fault
);
  logic drive_d;
  logic [1:0] stable_q;

  assign drive_d = i_state ^ i_test;

  // a one drives the pin, a zero releases it
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_drive <= `SSM_OUT_RST;
      o_oe_n <= ~`SSM_OUT_RST;
    end else begin
      o_drive <= drive_d;
      o_oe_n <= ~drive_d;
    end
  end

  // read-back only counts after the pin had time to settle through the synchroniser
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      stable_q <= 2'h0;
    end else if (drive_d != o_drive) begin
      stable_q <= 2'h0;
    end else if (stable_q != `SSM_SETTLE_CYCLES) begin
      stable_q <= stable_q + 2'h1;
    end
  end

  // mismatch on own test or because a neighbour pulled this pin
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_fault <= 1'b0;
    end else begin
      o_fault <= i_check && (stable_q == `SSM_SETTLE_CYCLES) && (i_fb != o_drive);
    end
  end
endmodule
`default_nettype wire

//--- rtl/ssm_top.sv
// safety i/o status monitor: input mapping, torque-off sequencing, status outputs
// and periodic output testing
// assumes pins and read-back are asynchronous; config and core status are on i_ref_clk
`include "ssm_consts.svh"
`default_nettype none
module ssm_top #(
  parameter int NUM_IN = 7,
  parameter int NUM_OUT = 4,
  parameter int DELAY_W = 32,
  parameter int SCAN_CYCLES = `SSM_SCAN_CYCLES,
  parameter int PULSE_CYCLES = `SSM_TEST_PULSE_CYCLES
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // activation pins from the safety controller
  input wire logic i_stop_one_request,
  input wire logic i_error_reset,
  input wire logic [NUM_IN-1:0] i_gen_in,
  // read-back of output pins: general outputs, then ack, then ready
  input wire logic [NUM_OUT+1:0] i_out_fb,
  // configuration
  input wire ssm_pkg::ssm_func_e [NUM_IN-1:0] i_in_assign,
  input wire ssm_pkg::ssm_ack_sel_e [NUM_OUT-1:0] i_out_assign,
  input wire logic [DELAY_W-1:0] i_torque_off_delay,
  // motion monitoring core
  input wire ssm_pkg::ssm_mon_s i_mon,
  // status output pins
  output logic [NUM_OUT-1:0] o_gen_out,
  output logic [NUM_OUT-1:0] o_gen_out_oe_n,
  output logic o_torque_off_ack,
  output logic o_torque_off_ack_oe_n,
  output logic o_ready,
  output logic o_ready_oe_n,
  // servo amplifier
  output logic o_pulse_disable,
  output logic o_brake_cmd,
  // to the monitoring core
  output ssm_pkg::ssm_func_vec_t o_func_active,
  output ssm_pkg::ssm_func_vec_t o_func_start,
  output logic o_stop_one_active,
  output logic o_error
);
  import ssm_pkg::*;

  localparam int NCH = NUM_OUT + 2;
  localparam int CH_ACK = NUM_OUT;
  localparam int CH_RDY = NUM_OUT + 1;
  localparam int CH_W = $clog2(NCH);
  localparam int SCAN_W = $clog2(SCAN_CYCLES);
  localparam int PULSE_W = $clog2(PULSE_CYCLES + 1);

  // refuse sizes the scheduler and mapping cannot serve
  if (NUM_IN < 1 || NUM_IN > 8) begin : g_bad_in
    $error("ssm_top: NUM_IN out of range");
  end
  if (NUM_OUT < 1 || NUM_OUT > 6) begin : g_bad_out
    $error("ssm_top: NUM_OUT out of range");
  end
  if (PULSE_CYCLES < 8) begin : g_bad_pulse
    $error("ssm_top: PULSE_CYCLES too short for read-back settling");
  end
  if (SCAN_CYCLES <= 2 * NCH * PULSE_CYCLES) begin : g_bad_scan
    $error("ssm_top: SCAN_CYCLES cannot hold one test round");
  end
  if (DELAY_W < 2 || DELAY_W > 32) begin : g_bad_delay
    $error("ssm_top: DELAY_W out of range");
  end

  // synchronised pins
  logic stop_in_s;
  logic reset_in_s;
  logic [NUM_IN-1:0] gen_in_s;
  logic [NCH-1:0] fb_s;

  // edge history
  logic stop_prev_q;
  logic reset_prev_q;
  logic [NUM_IN-1:0] gen_prev_q;
  logic limit_prev_q;

  // torque-off sequencing
  logic delay_run_q;
  logic [DELAY_W-1:0] delay_cnt_q;
  logic torque_off_q;
  logic torque_off_d;
  logic error_q;
  logic err_set;
  logic err_clear;
  logic stop_fall;
  logic reset_fall;
  logic limit_rise;
  logic both_low;
  logic delay_start;
  logic delay_expire;
  logic stop_one_busy;

  // function mapping
  ssm_func_vec_t func_req;
  ssm_func_vec_t func_edge;

  // output channels
  logic [NCH-1:0] ch_state;
  logic [NCH-1:0] ch_test;
  logic [NCH-1:0] ch_drive;
  logic [NCH-1:0] ch_oe_n;
  logic [NCH-1:0] ch_fault;
  logic [NUM_OUT-1:0] gen_state_q;
  logic ack_state_q;
  logic ready_state_q;
  logic standstill_ack;
  logic direction_ack;
  logic range_ack;

  // test scheduler
  ssm_scan_e scan_q;
  logic [SCAN_W-1:0] scan_cnt_q;
  logic [PULSE_W-1:0] pulse_cnt_q;
  logic [CH_W-1:0] chan_q;
  logic check_q;
  logic scan_wrap;
  logic phase_end;

  // pins cross into the clock domain; idle high so reset does not look like a request
  ssm_sync #(
    .W(NUM_IN + 2),
    .RST_VAL({(NUM_IN + 2){`SSM_PIN_IDLE}})
  ) u_sync_in (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_stop_one_request, i_error_reset, i_gen_in}),
    .o_sync({stop_in_s, reset_in_s, gen_in_s})
  );

  ssm_sync #(
    .W(NCH),
    .RST_VAL({NCH{`SSM_FB_RST}})
  ) u_sync_fb (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_out_fb),
    .o_sync(fb_s)
  );

  // previous levels for edge detection
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      stop_prev_q <= `SSM_PIN_IDLE;
      reset_prev_q <= `SSM_PIN_IDLE;
      gen_prev_q <= {NUM_IN{`SSM_PIN_IDLE}};
      limit_prev_q <= 1'b0;
    end else begin
      stop_prev_q <= stop_in_s;
      reset_prev_q <= reset_in_s;
      gen_prev_q <= gen_in_s;
      limit_prev_q <= i_mon.limit_violation;
    end
  end

  assign stop_fall = stop_prev_q & ~stop_in_s;
  assign reset_fall = reset_prev_q & ~reset_in_s;
  assign limit_rise = i_mon.limit_violation & ~limit_prev_q;
  assign both_low = ~stop_in_s & ~reset_in_s;
  assign err_set = i_mon.internal_error | (|ch_fault);
  assign err_clear = reset_in_s & ~reset_prev_q;

  // error latch: a new fault in the clearing cycle still latches
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      error_q <= 1'b0;
    end else if (err_set) begin
      error_q <= 1'b1;
    end else if (err_clear) begin
      error_q <= 1'b0;
    end
  end

  // the delay covers the braking ramp; a zero delay means no ramp at all
  assign delay_start = (stop_fall | reset_fall | limit_rise) & ~delay_run_q & ~torque_off_q;
  assign delay_expire = delay_run_q &
                        ((delay_cnt_q == DELAY_W'(1)) | i_mon.standstill_ok);

  always_comb begin
    torque_off_d = torque_off_q;
    if (both_low || error_q || err_set || delay_expire) begin
      torque_off_d = 1'b1;
    end else if (delay_start && (i_torque_off_delay == '0)) begin
      torque_off_d = 1'b1;
    end else if (torque_off_q && stop_in_s && reset_in_s && !i_mon.limit_violation) begin
      torque_off_d = 1'b0; // release only once both inputs are high and no error stands
    end
  end

  // torque-off delay timer
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      delay_run_q <= 1'b0;
      delay_cnt_q <= '0;
    end else if (torque_off_d) begin
      delay_run_q <= 1'b0;
      delay_cnt_q <= '0;
    end else if (delay_start) begin
      delay_run_q <= 1'b1;
      delay_cnt_q <= i_torque_off_delay;
    end else if (delay_run_q) begin
      delay_cnt_q <= delay_cnt_q - DELAY_W'(1);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      torque_off_q <= 1'b1;
    end else begin
      torque_off_q <= torque_off_d;
    end
  end

  // stop-one owns the drive while requested, ramping or holding torque off
  assign stop_one_busy = ~stop_in_s | delay_run_q | torque_off_q;

  // map each low input onto its configured function
  always_comb begin
    func_req = '0;
    func_edge = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (i_in_assign[i] != SSM_FN_NONE) begin
        func_req[i_in_assign[i]] = func_req[i_in_assign[i]] | ~gen_in_s[i];
        func_edge[i_in_assign[i]] = func_edge[i_in_assign[i]] |
                                    (gen_prev_q[i] & ~gen_in_s[i]);
      end
    end
    if (stop_one_busy) begin
      func_req = '0;
      func_edge = '0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_func_active <= '0;
      o_func_start <= '0;
      o_stop_one_active <= 1'b0;
      o_error <= 1'b0;
    end else begin
      o_func_active <= func_req;
      o_func_start <= func_edge;
      o_stop_one_active <= stop_one_busy;
      o_error <= error_q;
    end
  end

  // acknowledges are only one while their function group is monitored
  assign standstill_ack = i_mon.standstill_ok & (o_func_active[SSM_FN_STOP_TWO] |
                          o_func_active[SSM_FN_OPERATING_STOP] |
                          o_func_active[SSM_FN_LIMITED_INC]);
  assign direction_ack = i_mon.direction_ok & (o_func_active[SSM_FN_POS_DIR] |
                         o_func_active[SSM_FN_NEG_DIR]);
  assign range_ack = i_mon.range_ok & (o_func_active[SSM_FN_LIMITED_SPEED] |
                     o_func_active[SSM_FN_SPEED_RANGE] |
                     o_func_active[SSM_FN_LIMITED_INC]);

  // logical output states before test inversion
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      gen_state_q <= '0;
      ack_state_q <= 1'b1;
      ready_state_q <= 1'b0;
    end else begin
      for (int k = 0; k < NUM_OUT; k++) begin
        unique case (i_out_assign[k])
          SSM_ACK_STANDSTILL: gen_state_q[k] <= standstill_ack;
          SSM_ACK_DIRECTION: gen_state_q[k] <= direction_ack;
          SSM_ACK_RANGE: gen_state_q[k] <= range_ack;
          SSM_ACK_NONE: gen_state_q[k] <= 1'b0;
        endcase
      end
      ack_state_q <= torque_off_d;
      // the ack fault drops ready in the same cycle as it latches
      ready_state_q <= i_mon.startup_done & ~error_q & ~err_set & ~ch_fault[CH_ACK];
    end
  end

  // amplifier side: pulse-disable follows torque-off, brake is passed through
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_pulse_disable <= 1'b1;
      o_brake_cmd <= 1'b0;
    end else begin
      o_pulse_disable <= torque_off_d;
      o_brake_cmd <= i_mon.brake_request;
    end
  end

  // the scan counter free-runs so the round repeats at a fixed period
  assign scan_wrap = (scan_cnt_q == SCAN_W'(SCAN_CYCLES - 1));
  assign phase_end = (pulse_cnt_q == PULSE_W'(PULSE_CYCLES - 1));

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      scan_cnt_q <= '0;
    end else if (scan_wrap) begin
      scan_cnt_q <= '0;
    end else begin
      scan_cnt_q <= scan_cnt_q + SCAN_W'(1);
    end
  end

  // each round: per channel one inverted pulse, then an equal restore gap
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      scan_q <= SSM_SC_WAIT;
      pulse_cnt_q <= '0;
      chan_q <= '0;
      check_q <= 1'b0;
    end else begin
      check_q <= 1'b0;
      unique case (scan_q)
        SSM_SC_WAIT: begin
          pulse_cnt_q <= '0;
          chan_q <= '0;
          if (scan_wrap) begin
            scan_q <= SSM_SC_PULSE;
          end
        end
        SSM_SC_PULSE: begin
          if (phase_end) begin
            pulse_cnt_q <= '0;
            check_q <= 1'b1;
            scan_q <= SSM_SC_GAP;
          end else begin
            pulse_cnt_q <= pulse_cnt_q + PULSE_W'(1);
          end
        end
        SSM_SC_GAP: begin
          if (phase_end) begin
            pulse_cnt_q <= '0;
            check_q <= 1'b1;
            if (chan_q == CH_W'(NCH - 1)) begin
              scan_q <= SSM_SC_WAIT;
            end else begin
              chan_q <= chan_q + CH_W'(1);
              scan_q <= SSM_SC_PULSE;
            end
          end else begin
            pulse_cnt_q <= pulse_cnt_q + PULSE_W'(1);
          end
        end
        default: begin
          scan_q <= SSM_SC_WAIT;
        end
      endcase
    end
  end

  // the check strobe arrives one cycle after the pulse ends, while the drive
  // still shows the tested level, so the pulse itself is what is read back
  always_comb begin
    ch_test = '0;
    if (scan_q == SSM_SC_PULSE) begin
      ch_test[chan_q] = 1'b1;
    end
  end

  assign ch_state = {ready_state_q, ack_state_q, gen_state_q};

  for (genvar c = 0; c < NCH; c++) begin : g_chan
    ssm_out_chan u_chan (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_state(ch_state[c]),
      .i_test(ch_test[c]),
      .i_check(check_q),
      .i_fb(fb_s[c]),
      .o_drive(ch_drive[c]),
      .o_oe_n(ch_oe_n[c]),
      .o_fault(ch_fault[c])
    );
  end

  // pins straight from the channel drive flops
  assign o_gen_out = ch_drive[NUM_OUT-1:0];
  assign o_gen_out_oe_n = ch_oe_n[NUM_OUT-1:0];
  assign o_torque_off_ack = ch_drive[CH_ACK];
  assign o_torque_off_ack_oe_n = ch_oe_n[CH_ACK];
  assign o_ready = ch_drive[CH_RDY];
  assign o_ready_oe_n = ch_oe_n[CH_RDY];

endmodule
`default_nettype wire

//--- rtl/ssm_dummy_never_used.sv
// spare source, kept empty
`default_nettype none
`default_nettype wire

//--- bench/ssm_top_props.sv
// checker of the status monitor top: timing relations between its pins
// assumes synchronous active-low reset and a single reference clock
`default_nettype none
module ssm_top_props #(
  parameter int NUM_OUT = 4
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // watched inputs
  input wire logic i_stop_one_request,
  input wire logic i_error_reset,
  input wire ssm_pkg::ssm_mon_s i_mon,
  // watched outputs
  input wire logic [NUM_OUT-1:0] o_gen_out,
  input wire logic [NUM_OUT-1:0] o_gen_out_oe_n,
  input wire logic o_torque_off_ack,
  input wire logic o_torque_off_ack_oe_n,
  input wire logic o_ready,
  input wire logic o_pulse_disable,
  input wire logic o_brake_cmd,
  input wire ssm_pkg::ssm_func_vec_t o_func_active,
  input wire ssm_pkg::ssm_func_vec_t o_func_start,
  input wire logic o_stop_one_active,
  input wire logic o_error
);
  timeunit 1ns;
  timeprecision 1ps;
  import ssm_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // a driven pin must never also be released
  AST_GEN_OE: assert property (o_gen_out_oe_n == ~o_gen_out)
    else $error("general pin enable wrong");
  AST_ACK_OE: assert property (o_torque_off_ack_oe_n == ~o_torque_off_ack)
    else $error("ack pin enable wrong");
  // errors must cut motor power and readiness quickly
  AST_ERR_PD: assert property (o_error |-> ##[0:1] o_pulse_disable)
    else $error("error without pulse disable");
  AST_INT_ERR: assert property (i_mon.internal_error |-> ##[1:2] o_error)
    else $error("internal error not latched");
  AST_ERR_READY: assert property ($rose(o_error) |-> ##[0:2] !o_ready)
    else $error("ready kept on error");
  // stop-one blocks every other function; then start pulses, torque-off ack, brake forwarding and both-low torque off
  AST_STOP_PRIO: assert property (o_stop_one_active |-> o_func_active == '0 && o_func_start == '0)
    else $error("function active during stop");
  AST_START_ONE: assert property ((o_func_start & $past(o_func_start)) == '0)
    else $error("start longer than one cycle");
  AST_START_ACT: assert property (|o_func_start |-> (o_func_start & ~o_func_active) == '0)
    else $error("started function not active");
  AST_TO_ACK: assert property ($rose(o_pulse_disable) |-> ##[1:2] o_torque_off_ack)
    else $error("torque off not acknowledged");
  AST_BRAKE: assert property (o_brake_cmd == $past(i_mon.brake_request))
    else $error("brake command not forwarded");
  AST_BOTH_LOW: assert property (!i_stop_one_request && !i_error_reset |-> ##[1:5] o_pulse_disable)
    else $error("both pins low without torque off");
  // main scenarios reached
  cover property ($rose(o_error));
  cover property ($rose(o_pulse_disable) && o_stop_one_active);
  cover property (|o_func_start);
endmodule
bind ssm_top ssm_top_props #(.NUM_OUT(NUM_OUT)) i_props (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_stop_one_request(i_stop_one_request),
  .i_error_reset(i_error_reset), .i_mon(i_mon), .o_gen_out(o_gen_out),
  .o_gen_out_oe_n(o_gen_out_oe_n), .o_torque_off_ack(o_torque_off_ack),
  .o_torque_off_ack_oe_n(o_torque_off_ack_oe_n), .o_ready(o_ready),
  .o_pulse_disable(o_pulse_disable), .o_brake_cmd(o_brake_cmd), .o_func_active(o_func_active),
  .o_func_start(o_func_start), .o_stop_one_active(o_stop_one_active), .o_error(o_error));
`default_nettype wire

//--- bench/ssm_ctrl_model.sv
// model of the outside safety controller and the wiring of the card's outputs
// assumes levels from the test sequence; a released output reads 0 through the load
`default_nettype none
module ssm_ctrl_model (
  // levels asked for by the test sequence
  input wire logic i_stop_lvl,
  input wire logic i_reset_lvl,
  input wire logic [6:0] i_gen_lvl,
  input wire logic [5:0] i_short_mask,
  // card output pins
  input wire logic [3:0] i_gen_out,
  input wire logic [3:0] i_gen_out_oe_n,
  input wire logic i_ack,
  input wire logic i_ack_oe_n,
  input wire logic i_ready,
  input wire logic i_ready_oe_n,
  // activation pins and read-back
  output logic o_stop_one_request,
  output logic o_error_reset,
  output logic [6:0] o_gen_in,
  output logic [5:0] o_out_fb
);
  timeunit 1ns;
  timeprecision 1ps;
  // both fixed pins are always driven actively, never left open
  assign o_stop_one_request = i_stop_lvl;
  assign o_error_reset = i_reset_lvl;
  assign o_gen_in = i_gen_lvl;
  // released pins fall to 0; a masked pin is shorted to 0 V, which the card must notice
  assign o_out_fb = {i_ready & ~i_ready_oe_n, i_ack & ~i_ack_oe_n, i_gen_out & ~i_gen_out_oe_n}
    & ~i_short_mask;
endmodule
`default_nettype wire

//--- bench/ssm_top_tb.sv
// testbench of the status monitor top with a shortened output-test scan
// assumes the controller model wires pins back into the read-back inputs
`default_nettype none
module ssm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ssm_pkg::*;
  localparam int SCAN_C = 2000;
  localparam int PULSE_C = 10;
  logic ref_clk, rst_n, stop_lvl, reset_lvl, stop_pin, reset_pin, seen;
  logic [6:0] gen_lvl, gen_pin;
  logic [5:0] short_mask, out_fb, pins;
  logic [3:0] gen_out, gen_oe_n;
  logic ack, ack_oe_n, ready, ready_oe_n, pd, brake, stop_act, err;
  logic [31:0] delay;
  ssm_func_e [6:0] in_assign;
  ssm_ack_sel_e [3:0] out_assign;
  ssm_mon_s mon;
  ssm_func_vec_t f_act, f_start;
  int miscompares, n_checks, cycles, k, j, m, w, f;
  assign pins = {ready, ack, gen_out};
  ssm_top #(.SCAN_CYCLES(SCAN_C), .PULSE_CYCLES(PULSE_C)) i_dut (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_stop_one_request(stop_pin),
    .i_error_reset(reset_pin), .i_gen_in(gen_pin), .i_out_fb(out_fb), .i_in_assign(in_assign),
    .i_out_assign(out_assign), .i_torque_off_delay(delay), .i_mon(mon), .o_gen_out(gen_out),
    .o_gen_out_oe_n(gen_oe_n), .o_torque_off_ack(ack), .o_torque_off_ack_oe_n(ack_oe_n),
    .o_ready(ready), .o_ready_oe_n(ready_oe_n), .o_pulse_disable(pd), .o_brake_cmd(brake),
    .o_func_active(f_act), .o_func_start(f_start), .o_stop_one_active(stop_act), .o_error(err));
  ssm_ctrl_model i_ctrl (
    .i_stop_lvl(stop_lvl), .i_reset_lvl(reset_lvl), .i_gen_lvl(gen_lvl),
    .i_short_mask(short_mask), .i_gen_out(gen_out), .i_gen_out_oe_n(gen_oe_n), .i_ack(ack),
    .i_ack_oe_n(ack_oe_n), .i_ready(ready), .i_ready_oe_n(ready_oe_n),
    .o_stop_one_request(stop_pin), .o_error_reset(reset_pin), .o_gen_in(gen_pin),
    .o_out_fb(out_fb));
  // 200 MHz reference clock
  always #2.5 ref_clk = ~ref_clk;
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask
  // two samples 12 cycles apart, so one 10-cycle test inversion cannot cause a miss
  task chk_pins(input string nm, input logic [5:0] exp, input logic [5:0] msk);
    logic [5:0] s1;
    s1 = pins;
    cyc(12);
    chk(nm, exp & msk, (((s1 ^ exp) & (pins ^ exp) & msk) ^ exp) & msk);
  endtask
  // width of one test inversion on a pin and distance to the next
  task pulse(input int bi, input logic lv);
    for (j = 0; j < 2200 && pins[bi] !== lv; j++) cyc(1);
    for (w = 0; w < 40 && pins[bi] === lv; w++) cyc(1);
    for (j = 0; j < 2200 && pins[bi] !== lv; j++) cyc(1);
  endtask
  task clear_err();
    reset_lvl = 1'b0;
    cyc(6);
    reset_lvl = 1'b1;
    cyc(12);
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, well above the roughly 16000 cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 50000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    {stop_lvl, reset_lvl, gen_lvl, short_mask, mon} = {2'h3, 7'h00, 6'h00, 7'h00};
    foreach (in_assign[k]) in_assign[k] = ssm_func_e'(k);
    out_assign = {SSM_ACK_NONE, SSM_ACK_RANGE, SSM_ACK_DIRECTION, SSM_ACK_STANDSTILL};
    delay = 32'h0000_0032;
    cyc(6);
    rst_n = 1'b1;
    cyc(20);
    chk_pins("ready at start-up", 6'h00, 6'h3f);
    mon.startup_done = 1'b1;
    cyc(20);
    chk_pins("ready operational", 6'h20, 6'h3f);
    $display("test startup done");
    for (m = 0; m < 2; m++) begin
      if (m == 1) out_assign = {SSM_ACK_DIRECTION, SSM_ACK_NONE, SSM_ACK_STANDSTILL, SSM_ACK_RANGE};
      for (k = 0; k < 8; k++) begin
        {mon.range_ok, mon.direction_ok, mon.standstill_ok} = k[2:0];
        cyc(8);
        chk_pins("ack map", m ? {2'h2, k[1], 1'b0, k[0], k[2]} : {3'h4, k[2:0]}, 6'h3f);
      end
    end
    {gen_lvl, mon.range_ok, mon.direction_ok, mon.standstill_ok} = 10'h3f8;
    $display("test ack map done");
    cyc(8);
    foreach (in_assign[k]) in_assign[k] = ssm_func_e'((k + 3) % 7);
    for (k = 0; k < 7; k++) begin
      f = (k + 3) % 7;
      gen_lvl[k] = 1'b0;
      seen = 1'b0;
      for (j = 0; j < 8; j++) begin
        cyc(1);
        if (f_start[f] === 1'b1) seen = 1'b1;
      end
      chk("func start", 1, seen);
      chk("func active", 7'h01 << f, f_act);
      gen_lvl[k] = 1'b1;
      cyc(8);
      chk("func idle", 0, f_act);
    end
    $display("test input map done");
    gen_lvl[1] = 1'b0;
    mon.brake_request = 1'b1;
    cyc(8);
    stop_lvl = 1'b0;
    cyc(8);
    chk("stop priority", 0, f_act);
    chk("stop busy", 1, stop_act);
    chk("delay running", 0, pd);
    chk("brake", 1, brake);
    cyc(60);
    chk("delay expired", 1, pd);
    chk_pins("ack on", 6'h30, 6'h3f);
    stop_lvl = 1'b1;
    cyc(12);
    chk("torque back", 0, pd);
    chk("func resumes", 7'h10, f_act);
    gen_lvl[1] = 1'b1;
    delay = 32'h0000_03e8;
    reset_lvl = 1'b0;
    cyc(8);
    chk("reset pin delay", 1, stop_act);
    chk("one pin low", 0, pd);
    stop_lvl = 1'b0;
    cyc(6);
    chk("both low", 1, pd);
    {stop_lvl, reset_lvl} = 2'h3;
    cyc(12);
    $display("test stop done");
    mon.internal_error = 1'b1;
    cyc(1);
    mon.internal_error = 1'b0;
    cyc(4);
    chk("error latch", 1, err);
    chk("error power", 1, pd);
    chk_pins("error ready", 6'h10, 6'h30);
    clear_err();
    chk("error clear", 0, err);
    chk_pins("resume", 6'h20, 6'h3f);
    $display("test error done");
    {gen_lvl[4], mon.standstill_ok} = 2'h1;
    cyc(8);
    for (k = 0; k < 6; k++) begin
      pulse(k, (k == 1 || k == 5) ? 1'b0 : 1'b1);
      chk("test width", PULSE_C, w);
      chk("scan period", SCAN_C, w + j);
    end
    $display("test output pulses done");
    for (k = 1; k < 5; k = k + 3) begin
      short_mask[k] = 1'b1;
      for (j = 0; j < 2200 && err !== 1'b1; j++) cyc(1);
      chk("fault latch", 1, err);
      chk_pins("fault ready", 6'h00, 6'h20);
      short_mask = 6'h00;
      clear_err();
      chk("fault clear", 0, err);
    end
    $display("test faults done");
    wrap_up();
  end
endmodule
`default_nettype wire
